// File: core/pa_ctrl_pkg.sv
// What this block does
// (R1) Header address 0x3E opens ramp table access
// (R2) Eight one-byte entries, indexed by level select
// (R3) Index advances after each table byte
// (R4) Index wraps from seven back to zero
// (R5) Chip select high forces index to zero
// (R6) Host re-selects before reading back single write
// (R7) Burst bit and read/write bit steer access
// (R8) Sleep entry clears entries one through seven
// (R9) Shared pin tri-stated unless status programmed
// (R10) Chip select low: shared pin is serial out
// (R11) Serial modes: output zero becomes transmit input
// (R12) Test register picks temperature sensor availability
// (R13) Host restores test register before leaving idle
// (R14) Pin control only when enable bit set
// (R15) Host sets clock and data before select falls
// (R16) Select fall latches pins, issues state strobe
// (R17) Strobe only when it changes the state
// (R18) Power-down strobe waits for select release
// (R19) Select low is serial; wakes from sleep
// (R20) Header bit7 read/write, bit6 burst, six-bit address
// (R21) Pin control disabled: no strobe on select fall
// (R22) Select high: clock and data pins ignored
package pa_ctrl_pkg;

  // ****************************************************************
  // Serial header layout
  // ****************************************************************
  localparam int        HDR_RW_BIT    = 7;
  localparam int        HDR_BURST_BIT = 6;
  localparam int        HDR_ADDR_W    = 6;
  localparam logic [5:0] TABLE_ADDR   = 6'h3e;

  // ****************************************************************
  // Table and test register values
  // ****************************************************************
  localparam int         TABLE_DEPTH      = 8;
  localparam logic [7:0] TABLE_RESET      = 8'h00;
  localparam logic [7:0] TEST_REG_DEFAULT = 8'h7f;
  localparam logic [7:0] TEST_REG_IDLE    = 8'hbf;

  // ****************************************************************
  // Pin control codes, clock level then data level
  // ****************************************************************
  localparam logic [1:0] PC_POWER_DOWN = 2'h0;
  localparam logic [1:0] PC_TRANSMIT   = 2'h1;
  localparam logic [1:0] PC_IDLE       = 2'h2;
  localparam logic [1:0] PC_RECEIVE    = 2'h3;

  // ****************************************************************
  // Radio state reported by the main state machine
  // ****************************************************************
  typedef enum logic [2:0] {
    RS_SLEEP,
    RS_CRYSTAL_OFF,
    RS_IDLE,
    RS_RECEIVE,
    RS_TRANSMIT,
    RS_SYNTH_ON
  } radio_state_t;

endpackage

// File: core/pa_table_and_pin_control.sv
`timescale 1ns/1ns
`default_nettype none
module pa_table_and_pin_control
  import pa_ctrl_pkg::*;
#(
  parameter int DEPTH = TABLE_DEPTH
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        sclk_i,
  input  wire logic        si_i,
  output logic             shared_status_out_o,
  output logic             shared_status_out_oe_o,
  input  wire logic        status_fn_en_i,
  input  wire logic        status_one_i,
  input  wire logic [7:0]  status_byte_i,
  input  wire logic        general_output_zero_i,
  output logic             general_output_zero_o,
  output logic             general_output_zero_oe_o,
  input  wire logic        status_zero_i,
  input  wire logic        serial_mode_i,
  output logic             tx_serial_data_o,
  input  wire logic [7:0]  test_control_reg_i,
  output logic             temp_sensor_en_o,
  input  wire logic        pin_ctrl_en_i,
  input wire radio_state_t radio_state_i,
  input  wire logic        sleep_entry_i,
  input  wire logic [2:0]  pa_level_select_i,
  output logic [7:0]       pa_setting_o,
  output logic             power_down_strobe_o,
  output logic             transmit_strobe_o,
  output logic             idle_strobe_o,
  output logic             receive_strobe_o,
  output logic             wake_o
);

  localparam int IW = $clog2(DEPTH);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (DEPTH != TABLE_DEPTH) begin : g_bad_depth
    $error("Table depth must match the three-bit level select");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic {
    PH_HEADER,
    PH_DATA
  } phase_t;

  typedef struct packed {
    logic                  sel_n_m;
    logic                  sel_n_s;
    logic                  sel_n_p;
    logic                  sclk_m;
    logic                  sclk_s;
    logic                  sclk_p;
    logic                  si_m;
    logic                  si_s;
    logic                  gdo_m;
    logic                  gdo_s;
    phase_t                phase;
    logic [2:0]            bitcnt;
    logic [7:0]            sh_in;
    logic [7:0]            sh_out;
    logic [7:0]            next_out;
    logic                  reload;
    logic                  rw;
    logic                  burst;
    logic                  tbl;
    logic [IW-1:0]         idx;
    logic [DEPTH-1:0][7:0] table_q;
    logic                  pd_pend;
    logic                  pd_stb;
    logic                  tx_stb;
    logic                  idle_stb;
    logic                  rx_stb;
    logic                  wake;
    logic [7:0]            pa_set;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  logic   cs_fall;
  logic   sclk_rise;
  logic   sclk_fall;
  logic [1:0] pc_code;
  logic [7:0] byte_in;
  logic [IW-1:0] idx_nx;

  assign cs_fall   = fell(q.sel_n_p, q.sel_n_s);
  assign sclk_rise = fell(q.sclk_s, q.sclk_p) & ~q.sel_n_s;
  assign sclk_fall = fell(q.sclk_p, q.sclk_s) & ~q.sel_n_s;
  assign pc_code   = {q.sclk_s, q.si_s};
  assign byte_in   = {q.sh_in[6:0], q.si_s};
  assign idx_nx    = q.idx + IW'(1);                       // (R4)

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.sel_n_m  = chip_select_n_i;
    d.sel_n_s  = q.sel_n_m;
    d.sel_n_p  = q.sel_n_s;
    d.sclk_m   = sclk_i;
    d.sclk_s   = q.sclk_m;
    d.sclk_p   = q.sclk_s;
    d.si_m     = si_i;
    d.si_s     = q.si_m;
    d.gdo_m    = general_output_zero_i;
    d.gdo_s    = q.gdo_m;
    d.pd_stb   = 1'b0;
    d.tx_stb   = 1'b0;
    d.idle_stb = 1'b0;
    d.rx_stb   = 1'b0;
    d.wake     = 1'b0;
    d.pa_set   = q.table_q[pa_level_select_i];                 // (R2)

    if (q.sel_n_s) begin
      // Pin wiggles while deselected never reach the serial logic
      d.idx    = '0;                                           // (R5) (R22)
      d.phase  = PH_HEADER;
      d.bitcnt = 3'h0;
      d.reload = 1'b0;
      if (q.pd_pend) begin
        d.pd_stb  = 1'b1;                                      // (R18)
        d.pd_pend = 1'b0;
      end
    end

    if (cs_fall) begin
      d.sh_out = status_byte_i;
      if (radio_state_i == RS_SLEEP || radio_state_i == RS_CRYSTAL_OFF) begin
        d.wake = 1'b1;                                         // (R19)
      end
      if (pin_ctrl_en_i) begin                                 // (R14) (R21)
        case (pc_code)                                         // (R16)
          PC_POWER_DOWN: d.pd_pend  = radio_state_i != RS_SLEEP;   // (R17) (R18)
          PC_TRANSMIT:   d.tx_stb   = radio_state_i != RS_TRANSMIT; // (R17)
          PC_IDLE:       d.idle_stb = radio_state_i != RS_IDLE;  // (R17)
          PC_RECEIVE:    d.rx_stb   = radio_state_i != RS_RECEIVE; // (R17)
          default:       d.pd_pend  = q.pd_pend;
        endcase
      end
    end

    if (sclk_rise) begin                                       // (R19)
      d.sh_in  = byte_in;
      d.bitcnt = q.bitcnt + 3'h1;
      if (q.bitcnt == 3'h7) begin
        d.reload   = 1'b1;
        d.next_out = status_byte_i;
        if (q.phase == PH_HEADER) begin
          d.rw    = byte_in[HDR_RW_BIT];                       // (R20)
          d.burst = byte_in[HDR_BURST_BIT];                    // (R20)
          d.tbl   = byte_in[HDR_ADDR_W-1:0] == TABLE_ADDR;     // (R1)
          d.phase = PH_DATA;
          if (d.tbl && d.rw) begin
            d.next_out = q.table_q[q.idx];
          end
        end else begin
          if (q.tbl) begin
            if (!q.rw) begin
              d.table_q[q.idx] = byte_in;                      // (R7)
            end
            d.idx = idx_nx;                                    // (R3) (R4)
            if (q.rw && q.burst) begin
              d.next_out = q.table_q[idx_nx];
            end
          end
          if (!q.burst) begin
            d.phase = PH_HEADER;                               // (R7)
          end
        end
      end
    end

    if (sclk_fall) begin
      // Loading on the fall keeps the first bit of a byte valid before its rise
      if (q.reload) begin
        d.sh_out = q.next_out;
        d.reload = 1'b0;
      end else begin
        d.sh_out = {q.sh_out[6:0], 1'b0};
      end
    end

    if (sleep_entry_i) begin
      for (int i = 1; i < DEPTH; i++) begin
        d.table_q[i] = TABLE_RESET;                            // (R8)
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q         <= '0;
      q.sel_n_m <= 1'b1;
      q.sel_n_s <= 1'b1;
      q.sel_n_p <= 1'b1;
      q.phase   <= PH_HEADER;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ****************************************************************
  // Pins and outputs
  // ****************************************************************
  always_comb begin
    if (!q.sel_n_s) begin
      shared_status_out_oe_o = 1'b1;                           // (R10)
      shared_status_out_o    = q.sh_out[7];
    end else begin
      shared_status_out_oe_o = status_fn_en_i;                 // (R9)
      shared_status_out_o    = status_fn_en_i & status_one_i;
    end
  end

  // Transmit input uses the synchronised copy, so serial data lags the pin by two cycles
  assign general_output_zero_oe_o = ~(serial_mode_i && radio_state_i == RS_TRANSMIT); // (R11)
  assign general_output_zero_o    = general_output_zero_oe_o & status_zero_i;
  assign tx_serial_data_o         = ~general_output_zero_oe_o & q.gdo_s;              // (R11)

  assign temp_sensor_en_o = (radio_state_i == RS_SYNTH_ON || radio_state_i == RS_RECEIVE
                             || radio_state_i == RS_TRANSMIT)
                            || (radio_state_i == RS_IDLE && test_control_reg_i == TEST_REG_IDLE); // (R12)

  assign pa_setting_o        = q.pa_set;
  assign power_down_strobe_o = q.pd_stb;
  assign transmit_strobe_o   = q.tx_stb;
  assign idle_strobe_o       = q.idle_stb;
  assign receive_strobe_o    = q.rx_stb;
  assign wake_o              = q.wake;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_idx_clear;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && q.sel_n_s) |=> (q.idx == '0);
  endproperty
  a_idx_clear: assert property (p_idx_clear) else $error("Index not cleared while deselected"); // (R5)

  property p_idx_step;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && sclk_rise && q.bitcnt == 3'h7 && q.phase == PH_DATA && q.tbl)
      |=> (q.idx == $past(idx_nx));
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("Index did not advance"); // (R3)

  property p_idx_wrap;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && sclk_rise && q.bitcnt == 3'h7 && q.phase == PH_DATA && q.tbl && q.idx == IW'(DEPTH - 1))
      |=> (q.idx == '0);
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("Index did not wrap"); // (R4)

  property p_hdr_table;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && sclk_rise && q.bitcnt == 3'h7 && q.phase == PH_HEADER && byte_in[HDR_ADDR_W-1:0] == TABLE_ADDR)
      |=> (q.tbl && q.phase == PH_DATA && q.rw == $past(byte_in[HDR_RW_BIT]));
  endproperty
  a_hdr_table: assert property (p_hdr_table) else $error("Table header not decoded"); // (R1)

  property p_sleep_clear;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && sleep_entry_i) |=> (q.table_q[DEPTH-1] == TABLE_RESET && q.table_q[1] == TABLE_RESET
                                 && q.table_q[0] == $past(d.table_q[0]));
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("Sleep entry kept upper entries"); // (R8)

  property p_so_drive;
    @(posedge mclk_i) disable iff (rst_i)
    !q.sel_n_s |-> (shared_status_out_oe_o && shared_status_out_o == q.sh_out[7]);
  endproperty
  a_so_drive: assert property (p_so_drive) else $error("Serial out not driven while selected"); // (R10)

  property p_so_float;
    @(posedge mclk_i) disable iff (rst_i)
    (q.sel_n_s && !status_fn_en_i) |-> !shared_status_out_oe_o;
  endproperty
  a_so_float: assert property (p_so_float) else $error("Shared pin driven by default"); // (R9)

  property p_tx_strobe;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && cs_fall && pin_ctrl_en_i && pc_code == PC_TRANSMIT && radio_state_i != RS_TRANSMIT)
      |=> transmit_strobe_o ##1 !transmit_strobe_o;
  endproperty
  a_tx_strobe: assert property (p_tx_strobe) else $error("Transmit strobe missing"); // (R16)

  property p_no_restart;
    @(posedge mclk_i) disable iff (rst_i)
    (cs_fall && pc_code == PC_RECEIVE && radio_state_i == RS_RECEIVE) |=> !receive_strobe_o;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("Receive restarted"); // (R17)

  property p_pd_wait;
    @(posedge mclk_i) disable iff (rst_i)
    power_down_strobe_o |-> $past(q.sel_n_s) && $past(q.pd_pend);
  endproperty
  a_pd_wait: assert property (p_pd_wait) else $error("Power-down issued while selected"); // (R18)

  property p_pin_off;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && cs_fall && !pin_ctrl_en_i && !q.pd_pend)
      |=> !(transmit_strobe_o || idle_strobe_o || receive_strobe_o || q.pd_pend);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("Strobe with pin control disabled"); // (R21)

  property p_temp_idle;
    @(posedge mclk_i) disable iff (rst_i)
    (radio_state_i == RS_IDLE) |-> (temp_sensor_en_o == (test_control_reg_i == TEST_REG_IDLE));
  endproperty
  a_temp_idle: assert property (p_temp_idle) else $error("Idle sensor setting ignored"); // (R12)

  // Clock and data moves while deselected must leave the byte logic untouched
  property p_desel_quiet;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && q.sel_n_s) |=> (q.bitcnt == 3'h0 && $stable(q.sh_in));
  endproperty
  a_desel_quiet: assert property (p_desel_quiet) else $error("Serial logic moved while deselected"); // (R22)

  property p_wake;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && cs_fall && (radio_state_i == RS_SLEEP || radio_state_i == RS_CRYSTAL_OFF)) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("No wake on select from sleep"); // (R19)

  property p_idle_strobe;
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && cs_fall && pin_ctrl_en_i && pc_code == PC_IDLE && radio_state_i != RS_IDLE)
      |=> idle_strobe_o;
  endproperty
  a_idle_strobe: assert property (p_idle_strobe) else $error("Idle strobe missing"); // (R16)

endmodule
`default_nettype wire

// File: testbench/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input  wire logic mclk_i,
  input  wire logic so_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      si_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o   = 1'b0;
  end
  // ********
  // Bus cycles, half period 4 mclk for an 80 ns serial clock
  // ********
  task automatic half();
    repeat (4) @(negedge mclk_i);
  endtask
  task automatic select();
    @(negedge mclk_i);
    cs_n_o = 1'b0;
    repeat (6) @(negedge mclk_i);
  endtask
  task automatic deselect();
    @(negedge mclk_i);
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = ~si_o; // Released data line never shows its stale value
    repeat (10) @(negedge mclk_i);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_o = tx[i];
      half();
      sclk_o = 1'b1;
      half();
      rx[i] = so_i; // Late in the high phase: the pin only moves after the fall
      sclk_o = 1'b0;
    end
  endtask
  task automatic pin_cmd(input logic [1:0] code);
    @(negedge mclk_i);
    sclk_o = code[1];
    si_o   = code[0];
    repeat (4) @(negedge mclk_i);
    cs_n_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: testbench/pa_table_and_pin_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pa_table_and_pin_control_tb_top
  import pa_ctrl_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst, ce, cs_n, sclk, si, so, so_oe, fn_en, st_one, go_in, go_out, go_oe, st_zero, smode;
  logic         tx_dat, temp_en, pin_en, sleep, pd, txs, ids, rxs, wake;
  logic [7:0]   treg, pa_set, rx_b;
  logic [7:0]   tab[8];
  logic [2:0]   lvl;
  radio_state_t rs;
  int           cnt[5];
  int           error_cnt = 0;
  int           samples_checked = 0;

  always #5 mclk = ~mclk;

  pa_table_and_pin_control i_dut (
    .mclk_i(mclk), .rst_i(rst), .ce_i(ce), .chip_select_n_i(cs_n), .sclk_i(sclk), .si_i(si),
    .shared_status_out_o(so), .shared_status_out_oe_o(so_oe), .status_fn_en_i(fn_en),
    .status_one_i(st_one), .status_byte_i(8'h5a), .general_output_zero_i(go_in),
    .general_output_zero_o(go_out), .general_output_zero_oe_o(go_oe), .status_zero_i(st_zero),
    .serial_mode_i(smode), .tx_serial_data_o(tx_dat), .test_control_reg_i(treg),
    .temp_sensor_en_o(temp_en), .pin_ctrl_en_i(pin_en), .radio_state_i(rs), .sleep_entry_i(sleep),
    .pa_level_select_i(lvl), .pa_setting_o(pa_set), .power_down_strobe_o(pd),
    .transmit_strobe_o(txs), .idle_strobe_o(ids), .receive_strobe_o(rxs), .wake_o(wake));

  spi_host_model i_host (.mclk_i(mclk), .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));

  // ********
  // Strobe pulse counters
  // ********
  // Counted on the falling edge, away from the edge that launches the pulses
  always @(negedge mclk) begin
    cnt[0] += int'(pd === 1'b1);
    cnt[1] += int'(txs === 1'b1);
    cnt[2] += int'(ids === 1'b1);
    cnt[3] += int'(rxs === 1'b1);
    cnt[4] += int'(wake === 1'b1);
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic pa_levels(input logic [7:0] e0, input logic [7:0] erest, input logic use_tab);
    for (int l = 0; l < 8; l++) begin
      lvl = 3'(l);
      tick(2);
      check("pa_setting", pa_set, use_tab ? tab[l] : (l == 0 ? e0 : erest));
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ********
  // Watchdog, the tests need about 30 us
  // ********
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    {rst, ce, fn_en, st_one, go_in, st_zero, smode, pin_en, sleep} = 9'h1ff;
    {fn_en, st_one, go_in, smode, pin_en, sleep} = 6'h00;
    treg = TEST_REG_DEFAULT;
    lvl  = 3'h0;
    rs   = RS_IDLE;
    cnt  = '{default: 0};
    repeat (20) @(posedge mclk);
    tick(1);
    rst = 1'b0;
    tick(5);
    pa_levels(8'h00, 8'h00, 1'b0);
    check("so_oe", so_oe, 8'h00);
    $display("test reset done");
    // Burst write of all entries, then burst read
    i_host.select();
    check("so_oe", so_oe, 8'h01);
    i_host.xfer(8'h7e, rx_b);
    check("header_status", rx_b, 8'h5a);
    for (int i = 0; i < 8; i++) begin
      tab[i] = 8'h31 + 8'(i * 29);
      i_host.xfer(tab[i], rx_b);
    end
    i_host.deselect();
    pa_levels(8'h00, 8'h00, 1'b1);
    i_host.select();
    i_host.xfer(8'hfe, rx_b);
    for (int i = 0; i < 8; i++) begin
      i_host.xfer(8'h00, rx_b);
      check("burst_read", rx_b, tab[i]);
    end
    i_host.deselect();
    $display("test burst done");
    // Nine bytes wrap onto entry zero; single reads advance too
    i_host.select();
    i_host.xfer(8'h7e, rx_b);
    for (int i = 0; i < 9; i++) i_host.xfer(8'h40 + 8'(i), rx_b);
    i_host.deselect();
    i_host.select();
    i_host.xfer(8'hbe, rx_b);
    i_host.xfer(8'h00, rx_b);
    check("wrap_entry0", rx_b, 8'h48);
    i_host.xfer(8'hbe, rx_b);
    i_host.xfer(8'h00, rx_b);
    check("single_next", rx_b, 8'h41);
    i_host.deselect();
    i_host.select();
    i_host.xfer(8'h3d, rx_b);
    i_host.xfer(8'h99, rx_b);
    i_host.xfer(8'h3e, rx_b);
    i_host.xfer(8'hc3, rx_b);
    i_host.deselect();
    i_host.select();
    i_host.xfer(8'hbe, rx_b);
    i_host.xfer(8'h00, rx_b);
    check("readback", rx_b, 8'hc3);
    i_host.deselect();
    sleep = 1'b1;
    tick(1);
    sleep = 1'b0;
    pa_levels(8'hc3, 8'h00, 1'b0);
    ce  = 1'b0;
    lvl = 3'h0;
    tick(3);
    check("ce_frozen", pa_set, 8'h00);
    ce = 1'b1;
    tick(2);
    check("ce_resumed", pa_set, 8'hc3);
    $display("test table done");
    // Pin control from idle and from receive
    pin_en = 1'b1;
    for (int s = 0; s < 2; s++) begin
      rs = s ? RS_RECEIVE : RS_IDLE;
      for (int c = 0; c < 4; c++) begin
        cnt = '{default: 0};
        i_host.pin_cmd(2'(c));
        tick(12);
        check("pd_early", 8'(cnt[0]), 8'h00);
        check("tx_strobe", 8'(cnt[1]), 8'(c == 1));
        check("idle_strobe", 8'(cnt[2]), 8'(c == 2 && s == 1));
        check("rx_strobe", 8'(cnt[3]), 8'(c == 3 && s == 0));
        i_host.deselect();
        check("pd_late", 8'(cnt[0]), 8'(c == 0));
      end
    end
    pin_en = 1'b0;
    rs     = RS_SLEEP;
    cnt    = '{default: 0};
    i_host.pin_cmd(2'h1);
    tick(12);
    check("tx_disabled", 8'(cnt[1]), 8'h00);
    check("wake", 8'(cnt[4]), 8'h01);
    i_host.deselect();
    check("pd_disabled", 8'(cnt[0]), 8'h00);
    $display("test pin control done");
    // Shared pin, output zero and sensor
    fn_en  = 1'b1;
    st_one = 1'b1;
    tick(2);
    check("so_oe_status", so_oe, 8'h01);
    check("so_status", so, 8'h01);
    smode = 1'b1;
    rs    = RS_TRANSMIT;
    go_in = 1'b1;
    tick(4);
    check("go0_oe", go_oe, 8'h00);
    check("tx_data", tx_dat, 8'h01);
    smode = 1'b0;
    tick(4);
    check("go0_out", {tx_dat, go_oe, go_out}, 8'h03);
    rs = RS_IDLE;
    tick(2);
    check("temp_idle", temp_en, 8'h00);
    treg = TEST_REG_IDLE;
    tick(2);
    check("temp_idle_on", temp_en, 8'h01);
    treg = TEST_REG_DEFAULT;
    rs   = RS_RECEIVE;
    tick(2);
    check("temp_rx", temp_en, 8'h01);
    $display("test pins done");
    report_and_stop();
  end
endmodule
`default_nettype wire
